// file: hdl/flash_ctrl_regs.vh
`ifndef FLASH_CTRL_REGS_VH
`define FLASH_CTRL_REGS_VH

// register offsets
`define ADDR_TIMER 8'h02
`define ADDR_CURRENT 8'h03
`define ADDR_MODE 8'h04
`define ADDR_FAULT 8'h05
`define ADDR_MASK 8'h06
`define ADDR_IND 8'h07
`define ADDR_VBAT 8'h09

// reset values
`define RST_TIMER 8'h0F
`define RST_CURRENT 8'h00
`define RST_MODE 8'h80
`define RST_MASK 8'h00
`define RST_IND 8'h00
`define RST_VBAT 8'h00

// output_mode_control fields
`define STR_SRC_BIT 2
`define OUT_EN_BIT 3
`define FREQUENCY_FOLDBACK_BIT_BIT 4
`define STR_LEVEL_BIT 5
`define MODE_STBY 2'h0
`define MODE_5V 2'h1
`define MODE_ASSIST 2'h2
`define MODE_FLASH 2'h3

// flash_timer_config and strobe_indicator_control fields
`define TORCH_MASK1_PIN_MASK_BIT 4
`define INDICATOR_MASK2_PIN_MASK_BIT 5
`define STROBE_POLARITY_BIT_BIT 3

// fault information bits
`define FLT_TXMASK 0
`define FLT_DCLIM 3
`define FLT_TIMEOUT 4

// timing
`define CLK_FREQ_KHZ 100000
`define CLK_PERIOD_NS 10
`define FLASH_STEP_MS 100
`define RAMP_STEP_NS 2000

`endif

// file: hdl/flash_mode_ctrl.v
`include "flash_ctrl_regs.vh"
`default_nettype none

module flash_mode_ctrl #(
    parameter [23:0] STEP_CYCLES = `FLASH_STEP_MS * `CLK_FREQ_KHZ,
    parameter [6:0] DEV_ADDR = 7'h2A
) (
    // clock and reset
    input wire i_clk,
    input wire i_nrst,
    // device pins
    input wire i_en,
    input wire i_strobe,
    input wire i_torch_mask1_pin,
    input wire i_indicator_mask2_pin,
    // serial register port
    input wire i_scl,
    input wire i_sda,
    output wire o_sda_o,
    output wire o_sda_oe,
    // analog status
    input wire i_vbat_below,
    input wire i_dc_limit_hit,
    // analog controls
    output reg [4:0] o_led_current,
    output wire o_led_on,
    output wire o_flash_active,
    output wire o_boost_5v,
    output wire o_freq_foldback,
    output wire [1:0] o_input_limit,
    output wire [2:0] o_vbat_threshold,
    output wire [2:0] o_indicator_current,
    output wire o_indicator_en
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_5V = 3'h1;
    localparam [2:0] ST_ASSIST = 3'h2;
    localparam [2:0] ST_TORCH = 3'h3;
    localparam [2:0] ST_FLASH = 3'h4;
    localparam [23:0] STEP_LAST = STEP_CYCLES - 24'h000001;
    localparam integer RAMP_LAST = `RAMP_STEP_NS / `CLK_PERIOD_NS - 1;

    wire [5:0] pin;
    wire en_s = pin[0];
    wire strobe_s = pin[1];
    wire torch_mask1_pin_s = pin[2];
    wire indicator_mask2_pin_s = pin[3];
    wire vbat_s = pin[4];
    wire dc_s = pin[5];

    wire bus_wr;
    wire bus_rd;
    wire [7:0] bus_addr;
    wire [7:0] bus_wdata;
    reg [7:0] rdata;

    reg [7:0] timer_q;
    reg [7:0] current_q;
    reg [7:0] mode_q;
    reg [7:0] fault_q;
    reg [7:0] mask_q;
    reg [7:0] ind_q;
    reg [7:0] vbat_q;

    reg [2:0] st_q;
    reg [2:0] st_d;
    reg str_p_q;
    reg [23:0] cyc_q;
    reg [3:0] stp_q;
    reg [7:0] rcnt_q;
    reg boot_q;
    reg [4:0] tgt;
    reg start;
    reg ok;
    reg tmo;
    reg drop;
    reg [7:0] flt_set;

    pin_sync #(
        .W(6)
    ) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({i_dc_limit_hit, i_vbat_below, i_indicator_mask2_pin, i_torch_mask1_pin, i_strobe, i_en}),
        .o_q(pin)
    );

    i2c_reg_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_i2c (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .o_wr(bus_wr),
        .o_rd(bus_rd),
        .o_addr(bus_addr),
        .o_wdata(bus_wdata),
        .i_rdata(rdata)
    );

    // open drain: only ever pulls low
    assign o_sda_o = 1'b0;

    function is_wr;
        input [7:0] a;
        begin
            is_wr = bus_wr && (bus_addr == a);
        end
    endfunction

    wire [1:0] op_mode = mode_q[1:0];
    wire hw_strobe = mode_q[`STR_SRC_BIT];
    wire out_en = mode_q[`OUT_EN_BIT];
    wire level = mode_q[`STR_LEVEL_BIT];
    wire [3:0] flash_timer_field = timer_q[3:0];
    wire [4:0] flash_cur = current_q[7:3];
    wire [2:0] torch_cur = current_q[2:0];
    wire [2:0] vbat_thr = vbat_q[2:0];
    wire [4:0] vbat_red = vbat_q[7:3];
    wire torch_mask1_pin_mask = timer_q[`TORCH_MASK1_PIN_MASK_BIT];
    wire indicator_mask2_pin_mask = timer_q[`INDICATOR_MASK2_PIN_MASK_BIT];

    // strobe level as seen after polarity
    wire str_act = strobe_s ^ ind_q[`STROBE_POLARITY_BIT_BIT];
    wire str_edge = str_act & ~str_p_q;
    wire torch_pin = torch_mask1_pin_s & ~torch_mask1_pin_mask;
    wire tx1 = torch_mask1_pin_s & torch_mask1_pin_mask;
    wire tx2 = indicator_mask2_pin_s & indicator_mask2_pin_mask;
    wire blocked = fault_q[`FLT_TIMEOUT];

    wire step_tick = (cyc_q == STEP_LAST);
    wire expire = step_tick && (stp_q == flash_timer_field);
    wire ramp_tick = (rcnt_q == RAMP_LAST[7:0]);
    wire dc_event = boot_q && dc_s;

    always @* begin
        st_d = st_q;
        start = 1'b0;
        ok = 1'b0;
        tmo = 1'b0;
        drop = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (out_en && !blocked) begin
                    case (op_mode)
                        `MODE_5V: st_d = ST_5V;
                        `MODE_ASSIST: st_d = ST_ASSIST;
                        `MODE_FLASH: begin
                            // software strobe does not wait for the pin
                            if (!hw_strobe || (level ? str_act : str_edge)) begin
                                st_d = ST_FLASH;
                                start = 1'b1;
                            end
                        end
                        default: begin
                            if (torch_pin) begin
                                st_d = ST_TORCH;
                            end
                        end
                    endcase
                end
            end
            ST_5V: begin
                if (!out_en || op_mode != `MODE_5V) begin
                    st_d = ST_IDLE;
                end
            end
            ST_ASSIST: begin
                if (!out_en || op_mode != `MODE_ASSIST) begin
                    st_d = ST_IDLE;
                end
            end
            ST_TORCH: begin
                if (!torch_pin) begin
                    st_d = ST_IDLE;
                    drop = 1'b1;
                end else if (!out_en) begin
                    st_d = ST_IDLE;
                end else if (str_act) begin
                    st_d = ST_FLASH;
                    start = 1'b1;
                end
            end
            ST_FLASH: begin
                if (!out_en) begin
                    st_d = ST_IDLE;
                end else if (hw_strobe && level && !str_act) begin
                    st_d = ST_IDLE;
                    ok = 1'b1;
                end else if (expire) begin
                    st_d = ST_IDLE;
                    tmo = hw_strobe && level;
                    ok = !(hw_strobe && level);
                end else if (hw_strobe && !level && str_edge) begin
                    start = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always @* begin
        tgt = 5'h00;
        case (st_q)
            ST_ASSIST, ST_TORCH: tgt = {2'h0, torch_cur};
            ST_FLASH: begin
                tgt = flash_cur;
                if (vbat_thr != 3'h0 && vbat_s && vbat_red < flash_cur) begin
                    tgt = vbat_red;
                end
                // first mask has priority when both are up
                if (tx1) begin
                    tgt = {1'b0, mask_q[3:0]};
                end else if (tx2) begin
                    tgt = {1'b0, mask_q[7:4]};
                end
            end
            default: tgt = 5'h00;
        endcase
    end

    always @* begin
        flt_set = 8'h00;
        flt_set[`FLT_TIMEOUT] = tmo;
        flt_set[`FLT_DCLIM] = dc_event;
        flt_set[`FLT_TXMASK] = (st_q == ST_FLASH) && (tx1 || tx2);
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ST_IDLE;
            str_p_q <= 1'b0;
            cyc_q <= 24'h000000;
            stp_q <= 4'h0;
            rcnt_q <= 8'h00;
            boot_q <= 1'b0;
            o_led_current <= 5'h00;
        end else begin
            st_q <= st_d;
            str_p_q <= str_act;
            if (start || st_q != ST_FLASH) begin
                cyc_q <= 24'h000000;
                stp_q <= 4'h0;
            end else if (step_tick) begin
                cyc_q <= 24'h000000;
                stp_q <= stp_q + 4'h1;
            end else begin
                cyc_q <= cyc_q + 24'h000001;
            end
            rcnt_q <= ramp_tick ? 8'h00 : rcnt_q + 8'h01;
            if (st_d != ST_FLASH || dc_event || (st_q == ST_FLASH && o_led_current >= tgt)) begin
                boot_q <= 1'b0;
            end else if (start && st_q != ST_FLASH) begin
                boot_q <= 1'b1;
            end
            // drops apply at once, rises creep to keep battery current smooth
            if (st_q != ST_ASSIST && st_q != ST_TORCH && st_q != ST_FLASH) begin
                o_led_current <= 5'h00;
            end else if (tgt < o_led_current) begin
                o_led_current <= tgt;
            end else if (ramp_tick && o_led_current < tgt && !dc_event) begin
                o_led_current <= o_led_current + 5'h01;
            end
        end
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            timer_q <= `RST_TIMER;
            current_q <= `RST_CURRENT;
            mode_q <= `RST_MODE;
            fault_q <= 8'h00;
            mask_q <= `RST_MASK;
            ind_q <= `RST_IND;
            vbat_q <= `RST_VBAT;
        end else if (!en_s) begin
            // held at defaults while enable is low, so each rise starts clean
            timer_q <= `RST_TIMER;
            current_q <= `RST_CURRENT;
            mode_q <= `RST_MODE;
            fault_q <= 8'h00;
            mask_q <= `RST_MASK;
            ind_q <= `RST_IND;
            vbat_q <= `RST_VBAT;
        end else begin
            if (is_wr(`ADDR_TIMER)) timer_q <= bus_wdata;
            if (dc_event) begin
                current_q[7:3] <= o_led_current;
            end else if (is_wr(`ADDR_CURRENT)) begin
                current_q <= bus_wdata;
            end
            if (is_wr(`ADDR_MODE)) begin
                mode_q <= bus_wdata;
            end else if (ok || tmo || drop) begin
                mode_q[`OUT_EN_BIT] <= 1'b0;
                if (ok) mode_q[1:0] <= `MODE_STBY;
            end
            if (is_wr(`ADDR_MASK)) mask_q <= bus_wdata;
            if (is_wr(`ADDR_IND)) ind_q <= bus_wdata;
            if (is_wr(`ADDR_VBAT)) vbat_q <= bus_wdata;
            // new events win over the clear from a read
            if (bus_rd && bus_addr == `ADDR_FAULT) begin
                fault_q <= flt_set;
            end else begin
                fault_q <= fault_q | flt_set;
            end
        end
    end

    always @* begin
        case (bus_addr)
            `ADDR_TIMER: rdata = timer_q;
            `ADDR_CURRENT: rdata = current_q;
            `ADDR_MODE: rdata = mode_q;
            `ADDR_FAULT: rdata = fault_q;
            `ADDR_MASK: rdata = mask_q;
            `ADDR_IND: rdata = ind_q;
            `ADDR_VBAT: rdata = vbat_q;
            default: rdata = 8'h00;
        endcase
    end

    assign o_led_on = (st_q == ST_ASSIST) || (st_q == ST_TORCH) || (st_q == ST_FLASH);
    assign o_flash_active = (st_q == ST_FLASH);
    assign o_boost_5v = (st_q == ST_5V);
    assign o_freq_foldback = mode_q[`FREQUENCY_FOLDBACK_BIT_BIT];
    assign o_input_limit = mode_q[7:6];
    assign o_vbat_threshold = vbat_thr;
    assign o_indicator_current = ind_q[2:0];
    // the host keeps this off during flash or torch; not enforced here
    assign o_indicator_en = en_s & ~indicator_mask2_pin_mask;
endmodule

`default_nettype wire

// file: hdl/i2c_reg_slave.v
`default_nettype none

module i2c_reg_slave #(
    parameter [6:0] DEV_ADDR = 7'h2A
) (
    // clock and reset
    input wire i_clk,
    input wire i_nrst,
    // serial pins
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_oe,
    // register access
    output reg o_wr,
    output reg o_rd,
    output reg [7:0] o_addr,
    output reg [7:0] o_wdata,
    input wire [7:0] i_rdata
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_REG = 3'h2;
    localparam [2:0] S_WDAT = 3'h3;
    localparam [2:0] S_RDAT = 3'h4;
    localparam [2:0] S_MACK = 3'h5;

    reg [1:0] scl_m;
    reg [1:0] sda_m;
    reg scl_p;
    reg sda_p;
    reg [2:0] st;
    reg [3:0] cnt;
    reg [7:0] sr;
    reg rw;
    reg ack;

    wire scl = scl_m[1];
    wire sda = sda_m[1];
    wire start = scl & scl_p & sda_p & ~sda;
    wire stop = scl & scl_p & ~sda_p & sda;
    wire rise = scl & ~scl_p;
    wire fall = ~scl & scl_p;
    wire rx = (st == S_ADDR) || (st == S_REG) || (st == S_WDAT);

    // read strobe fires as the byte is captured, so read-clear sees it once
    task load_byte;
        begin
            sr <= i_rdata;
            o_rd <= 1'b1;
            o_sda_oe <= ~i_rdata[7];
            cnt <= 4'h1;
            st <= S_RDAT;
        end
    endtask

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_m <= 2'h3;
            sda_m <= 2'h3;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            st <= S_IDLE;
            cnt <= 4'h0;
            sr <= 8'h00;
            rw <= 1'b0;
            ack <= 1'b0;
            o_sda_oe <= 1'b0;
            o_wr <= 1'b0;
            o_rd <= 1'b0;
            o_addr <= 8'h00;
            o_wdata <= 8'h00;
        end else begin
            scl_m <= {scl_m[0], i_scl};
            sda_m <= {sda_m[0], i_sda};
            scl_p <= scl;
            sda_p <= sda;
            o_wr <= 1'b0;
            o_rd <= 1'b0;
            if (start) begin
                st <= S_ADDR;
                cnt <= 4'h0;
                ack <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (stop) begin
                st <= S_IDLE;
                ack <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (rise) begin
                if (st == S_MACK && sda) begin
                    st <= S_IDLE;
                end else if (rx && !ack) begin
                    sr <= {sr[6:0], sda};
                    cnt <= cnt + 4'h1;
                end
            end else if (fall) begin
                if (ack) begin
                    ack <= 1'b0;
                    o_sda_oe <= 1'b0;
                    cnt <= 4'h0;
                    if (st == S_ADDR && rw) begin
                        load_byte;
                    end else if (st == S_ADDR) begin
                        st <= S_REG;
                    end else if (st == S_REG) begin
                        st <= S_WDAT;
                    end else begin
                        o_addr <= o_addr + 8'h01;
                    end
                end else if (st == S_RDAT) begin
                    if (cnt == 4'h8) begin
                        o_sda_oe <= 1'b0;
                        o_addr <= o_addr + 8'h01;
                        st <= S_MACK;
                    end else begin
                        o_sda_oe <= ~sr[6];
                        sr <= {sr[6:0], 1'b0};
                        cnt <= cnt + 4'h1;
                    end
                end else if (st == S_MACK) begin
                    load_byte;
                end else if (cnt == 4'h8) begin
                    case (st)
                        S_ADDR: begin
                            if (sr[7:1] == DEV_ADDR) begin
                                rw <= sr[0];
                                ack <= 1'b1;
                                o_sda_oe <= 1'b1;
                            end else begin
                                st <= S_IDLE;
                            end
                        end
                        S_REG: begin
                            o_addr <= sr;
                            ack <= 1'b1;
                            o_sda_oe <= 1'b1;
                        end
                        S_WDAT: begin
                            o_wdata <= sr;
                            o_wr <= 1'b1;
                            ack <= 1'b1;
                            o_sda_oe <= 1'b1;
                        end
                        default: begin
                            st <= S_IDLE;
                        end
                    endcase
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: hdl/pin_sync.v
`default_nettype none

module pin_sync #(
    parameter W = 6
) (
    // clock and reset
    input wire i_clk,
    input wire i_nrst,
    // asynchronous pins in, synchronised levels out
    input wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

`default_nettype wire

// file: sim/flash_host_model.sv
`default_nettype none

module flash_host_model (
    // clock
    input wire logic i_clk,
    // serial bus
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic nack;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        nack = 1'b0;
    end
    // eight clocks a half bit, well above the four the slave needs
    task automatic hp;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
    task automatic bo(input logic b);
        o_sda_low = !b;
        hp();
        o_scl = 1'b1;
        hp();
        o_scl = 1'b0;
    endtask
    task automatic bi(output logic b);
        o_sda_low = 1'b0;
        hp();
        o_scl = 1'b1;
        hp();
        b = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic byo(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) bo(d[i]);
        bi(nack);
    endtask
    task automatic start;
        o_sda_low = 1'b0;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda_low = 1'b1;
        hp();
        o_scl = 1'b0;
    endtask
    task automatic stop;
        o_sda_low = 1'b1;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda_low = 1'b0;
        hp();
    endtask
    // plain register write; nothing here keeps the indicator off during an event
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
        start();
        byo({dev, 1'b0});
        byo(a);
        byo(d);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        start();
        byo(8'h54);
        byo(a);
        start();
        byo(8'h55);
        for (int i = 7; i >= 0; i--) bi(d[i]);
        bo(1'b1);
        stop();
    endtask
endmodule

`default_nettype wire

// file: sim/flash_mode_ctrl_checker.sv
`default_nettype none

module flash_mode_ctrl_checker #(
    parameter [23:0] STEP_CYCLES = 24'h000190
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // pins
    input wire logic i_en,
    // analog controls
    input wire logic [4:0] o_led_current,
    input wire logic o_led_on,
    input wire logic o_flash_active,
    input wire logic o_boost_5v,
    input wire logic [1:0] o_input_limit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    logic [31:0] flash_cnt_q;
    logic [31:0] flash_cnt_d;
    assign flash_cnt_d = o_flash_active ? flash_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flash_cnt_q <= 32'h0;
        end else begin
            flash_cnt_q <= flash_cnt_d;
        end
    end

    AST_FLASH_MAX: assert property (flash_cnt_q <= {8'h00, STEP_CYCLES} * 32'h10)
        else $error("flash lasted beyond the longest timer");
    AST_FLASH_LIT: assert property (o_flash_active |-> o_led_on)
        else $error("flash without led");
    AST_MODES_EXCL: assert property (!(o_boost_5v && o_led_on))
        else $error("5 V output and led together");
    AST_OFF_ZERO: assert property ((!o_led_on) [*2] |-> o_led_current == 5'h00)
        else $error("current while led off");
    AST_EN_LOW_OFF: assert property ((!i_en) [*8] |-> !o_led_on && !o_boost_5v)
        else $error("output active with enable low");
    AST_EN_LOW_LIMIT: assert property ((!i_en) [*8] |-> o_input_limit == 2'h2)
        else $error("limit not default with enable low");
    AST_RAMP_UP: assert property (o_led_on && $past(o_led_on)
        |-> {1'b0, o_led_current} <= {1'b0, $past(o_led_current)} + 6'h01)
        else $error("current rose faster than one step");
    AST_FLASH_END: assert property ($fell(o_flash_active) |=> (!o_led_on) [*4])
        else $error("led still on after flash");
endmodule

bind flash_mode_ctrl flash_mode_ctrl_checker #(.STEP_CYCLES(STEP_CYCLES)) chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_en(i_en), .o_led_current(o_led_current),
    .o_led_on(o_led_on), .o_flash_active(o_flash_active), .o_boost_5v(o_boost_5v),
    .o_input_limit(o_input_limit)
);

`default_nettype wire

// file: sim/flash_mode_ctrl_tb.sv
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module flash_mode_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_nrst, i_en, i_strobe, i_torch_mask1_pin, i_indicator_mask2_pin, i_vbat_below, i_dc_limit_hit;
    wire logic i_scl, i_sda, sda_low, o_sda_o, o_sda_oe, o_led_on, o_flash_active;
    wire logic o_boost_5v, o_freq_foldback, o_indicator_en;
    wire logic [4:0] o_led_current;
    wire logic [1:0] o_input_limit;
    wire logic [2:0] o_vbat_threshold, o_indicator_current;
    int errors = 0, samples_checked = 0, flen = 0, f0 = 0, n;
    logic [7:0] rd;

    assign i_sda = !(sda_low || o_sda_oe);
    flash_host_model host (.i_clk(i_clk), .o_scl(i_scl), .o_sda_low(sda_low), .i_sda(i_sda));
    flash_mode_ctrl #(.STEP_CYCLES(24'h000190)) DUT (.i_clk, .i_nrst, .i_en, .i_strobe,
        .i_torch_mask1_pin, .i_indicator_mask2_pin, .i_scl, .i_sda, .o_sda_o, .o_sda_oe, .i_vbat_below,
        .i_dc_limit_hit, .o_led_current, .o_led_on, .o_flash_active, .o_boost_5v,
        .o_freq_foldback, .o_input_limit, .o_vbat_threshold, .o_indicator_current,
        .o_indicator_en);

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_flash_active === 1'b1) flen <= flen + 1;

    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(7'h2A, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, rd);
        `CHK(rd, e)
    endtask
    task automatic wait_flash;
        tick(10);
        n = 0;
        while (o_flash_active !== 1'b0 && n < 10000) begin
            tick(1);
            n++;
        end
        tick(5);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge i_clk);
        errors++;
        report_and_stop();
    end

    initial begin
        {i_nrst, i_en, i_strobe, i_torch_mask1_pin, i_indicator_mask2_pin, i_vbat_below, i_dc_limit_hit} = 7'h00;
        tick(6);
        i_nrst = 1'b1;
        tick(4);
        wr(8'h04, 8'h8A);
        i_en = 1'b1;
        tick(5);
        rdchk(8'h04, 8'h80);
        rdchk(8'h02, 8'h0F);
        rdchk(8'h0A, 8'h00);
        `CHK(o_sda_o, 1'b0)
        `CHK(o_input_limit, 2'h2)
        `CHK(o_indicator_en, 1'b1)
        for (int c = 0; c < 4; c++) begin
            wr(8'h04, {c[1:0], 6'h10});
            `CHK(o_input_limit, c[1:0])
            `CHK(o_freq_foldback, 1'b1)
        end
        host.write_reg(7'h2B, 8'h09, 8'h07);
        `CHK(host.nack, 1'b1)
        `CHK(o_vbat_threshold, 3'h0)
        wr(8'h09, 8'h07);
        `CHK(o_vbat_threshold, 3'h7)
        wr(8'h07, 8'h05);
        `CHK(o_indicator_current, 3'h5)
        i_en = 1'b0;
        tick(5);
        i_en = 1'b1;
        tick(5);
        rdchk(8'h09, 8'h00);
        $display("registers done");
        wr(8'h04, 8'h89);
        `CHK(o_boost_5v, 1'b1)
        wr(8'h03, 8'h03);
        wr(8'h04, 8'h8A);
        tick(1000);
        `CHK(o_led_current, 5'h03)
        wr(8'h04, 8'h82);
        tick(4);
        `CHK(o_led_on, 1'b0)
        $display("modes done");
        wr(8'h02, 8'h01);
        f0 = flen;
        wr(8'h04, 8'h8B);
        wait_flash();
        `CHK(flen - f0, 800)
        rdchk(8'h04, 8'h80);
        wr(8'h04, 8'hAF);
        f0 = flen;
        i_strobe = 1'b1;
        tick(100);
        `CHK(o_flash_active, 1'b1)
        i_strobe = 1'b0;
        wait_flash();
        `CHK(flen - f0 > 90 && flen - f0 < 800, 1'b1)
        rdchk(8'h04, 8'hA4);
        wr(8'h04, 8'hAF);
        f0 = flen;
        i_strobe = 1'b1;
        wait_flash();
        `CHK(flen - f0, 800)
        i_strobe = 1'b0;
        rdchk(8'h05, 8'h10);
        rdchk(8'h05, 8'h00);
        $display("strobe level done");
        wr(8'h07, 8'h08);
        i_strobe = 1'b1;
        f0 = flen;
        wr(8'h04, 8'h8F);
        tick(50);
        `CHK(o_flash_active, 1'b0)
        i_strobe = 1'b0;
        tick(20);
        i_strobe = 1'b1;
        wait_flash();
        `CHK(flen - f0, 800)
        i_strobe = 1'b0;
        wr(8'h07, 8'h00);
        $display("strobe edge done");
        wr(8'h04, 8'h88);
        i_torch_mask1_pin = 1'b1;
        tick(10);
        `CHK(o_led_on, 1'b1)
        i_torch_mask1_pin = 1'b0;
        tick(10);
        `CHK(o_led_on, 1'b0)
        rdchk(8'h04, 8'h80);
        wr(8'h04, 8'h88);
        i_torch_mask1_pin = 1'b1;
        tick(10);
        i_strobe = 1'b1;
        tick(10);
        `CHK(o_flash_active, 1'b1)
        {i_torch_mask1_pin, i_strobe} = 2'h0;
        wait_flash();
        wr(8'h04, 8'h88);
        i_torch_mask1_pin = 1'b1;
        tick(10);
        i_torch_mask1_pin = 1'b0;
        tick(10);
        i_strobe = 1'b1;
        tick(10);
        `CHK(o_flash_active, 1'b0)
        i_strobe = 1'b0;
        $display("torch done");
        wr(8'h02, 8'h3F);
        wr(8'h06, 8'h21);
        wr(8'h03, 8'h50);
        wr(8'h04, 8'h8B);
        tick(2500);
        `CHK(o_led_current, 5'h0A)
        i_indicator_mask2_pin = 1'b1;
        tick(5);
        `CHK(o_led_current, 5'h02)
        i_torch_mask1_pin = 1'b1;
        tick(5);
        `CHK(o_led_current, 5'h01)
        {i_torch_mask1_pin, i_indicator_mask2_pin} = 2'h0;
        tick(10);
        `CHK(o_led_current < 5'h0A, 1'b1)
        `CHK(o_flash_active, 1'b1)
        `CHK(o_indicator_en, 1'b0)
        wait_flash();
        rdchk(8'h05, 8'h01);
        i_dc_limit_hit = 1'b1;
        wr(8'h04, 8'h8B);
        i_dc_limit_hit = 1'b0;
        rdchk(8'h03, 8'h00);
        wait_flash();
        rdchk(8'h05, 8'h08);
        $display("mask done");
        report_and_stop();
    end
endmodule

`default_nettype wire
